// *** modem_status_map.svh ***
// address map, field positions, reset values and timing figures of the status area
`ifndef MODEM_STATUS_MAP_SVH
`define MODEM_STATUS_MAP_SVH

// shared ram locations of the status area
`define MSR_ADDR_ERROR      6'h08
`define MSR_ADDR_GENERAL0   6'h09
`define MSR_ADDR_GENERAL1   6'h0a
`define MSR_ADDR_QUALITY    6'h0b
`define MSR_ADDR_OPT_LOW    6'h0c
`define MSR_ADDR_OPT_MID    6'h0d
`define MSR_ADDR_OPT_HIGH   6'h0e

// interrupt selection defaults
`define MSR_MASK0_RST       8'h3f
`define MSR_MASK1_RST       8'hff

// first general status byte
`define MSR_G0_CARRIER      0
`define MSR_G0_DSR          1
`define MSR_G0_CTS          2
`define MSR_G0_BELL         3
`define MSR_G0_CPT_LOW      4
`define MSR_G0_CPT_HIGH     5
`define MSR_G0_LOW_GT_HIGH  6
`define MSR_G0_FAST_CARRIER 7

// second general status byte
`define MSR_G1_TX_SYNC      0
`define MSR_G1_TIMEOUT      1
`define MSR_G1_TONE_DISC    2
`define MSR_G1_ANSWER_TONE  3
`define MSR_G1_RETRAIN      4
`define MSR_G1_RATE_NEG     5
`define MSR_G1_CLEARDOWN    6
`define MSR_G1_DIGIT        7

// line quality ceiling
`define MSR_QUALITY_MAX     8'h7f

// ring timing, in the units printed
`define MSR_BAUD_HZ         2400
`define MSR_RING_LOST_MS    20
`define MSR_RING_MIN_HZ     15
`define MSR_RING_MAX_HZ     68

`endif

// *** modem_status_pkg.sv ***
// types shared by the modem status reporting block
package modem_status_pkg;

    // operating mode chosen by the configure command
    typedef enum logic [2:0] {
        MODE_TONE  = 3'h0,
        MODE_DTMF  = 3'h1,
        MODE_DATA  = 3'h2,
        MODE_FAX   = 3'h3,
        MODE_VOICE = 3'h4
    } op_mode_t;

    // ring detector, gray along idle -> armed -> on
    typedef enum logic [1:0] {
        RING_IDLE  = 2'b00,
        RING_ARMED = 2'b01,
        RING_ON    = 2'b11
    } ring_st_t;

    // complete state of the block
    typedef struct packed {
        logic       ring_s1;
        logic       ring_s2;
        logic       ring_prev;
        ring_st_t   ring_st;
        logic [7:0] ring_cnt;
        logic [7:0] ring_idle;
        logic [7:0] ring_period;
        op_mode_t   mode;
        logic [7:0] mask0;
        logic [7:0] mask1;
        logic [2:0] src_sel;
        logic [7:0] stat0;
        logic [7:0] stat1;
        logic [7:0] quality;
        logic       quality_ok;
        logic [7:0] opt0;
        logic [7:0] opt1;
        logic [7:0] opt2;
        logic       dtmf_prev;
        logic [7:0] digit;
        logic       irq;
        logic [7:0] rd_data;
        logic       rxd;
    } msr_state_t;

endpackage

// *** modem_status_reporting.sv ***
// status bytes of the modem data pump: general, quality and optional status
//
// Overview of operation
// - raise status change interrupt when a selected general status bit changes
// - interrupt selection defaults to 3f for first byte, ff for second
// - modem mode bit 0 is carrier detect; while low received data is mark
// - modem mode bit 1 of first byte follows data set ready
// - modem mode bit 2 of first byte sets when training completes
// - tone modes: ring bit sets after one 15-68Hz period, clears 20ms later
// - tone modes: bits 4 and 5 report low-pass and high-pass detectors
// - tone modes: bit 6 set when low-pass signal exceeds high-pass signal
// - bit 7 of first byte is fast carrier, meaningful in fax mode only
// - modem mode bit 0 of second byte shows transmit sync in progress
// - data mode only: bit 1 of second byte flags handshake timeout
// - bit 2 of second byte tells which answer tone was detected
// - bit 3 of second byte flags answer tone; host samples bit 2 then
// - bit 4: remote retrain in data modes, receiver sync in fax modes
// - data mode only: bit 5 reports rate negotiation, bit 6 reports cleardown
// - touch-tone mode: bit 7 flags a digit, value in third optional byte
// - quality byte refreshed every baud, range 127 best down to 0
// - quality follows receive mode and is invalid in fsk modes
// - each configure command reloads optional sources with mode defaults, unless a source select comes in the same cycle
// - tone mode: optional bytes 0 and 1 hold the 16 tone detectors
// - tone mode: third optional byte holds ring period in 1/2400 s
// - touch-tone digit valid at flag rise, held until next digit
// - all status bytes refreshed once per baud
// - status area sits at 08..0e of shared ram in fixed order
`timescale 1ns/1ps
`include "modem_status_map.svh"

module modem_status_reporting
    import modem_status_pkg::*;
#(
    parameter int BAUD_HZ = `MSR_BAUD_HZ
) (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    // baud timing
    input  wire logic       i_baud_tick,
    // host commands
    input  wire logic       i_configure_cmd,
    input  wire logic [2:0] i_operating_mode_field,
    input  wire logic       i_select_status_irq_cmd,
    input  wire logic [7:0] i_irq_select0,
    input  wire logic [7:0] i_irq_select1,
    input  wire logic       i_optional_source_select_cmd,
    input  wire logic [2:0] i_optional_source_sel,
    input  wire logic [7:0] i_monitor_low,
    input  wire logic [7:0] i_monitor_mid,
    input  wire logic [7:0] i_monitor_high,
    // modem signals from the data pump
    input  wire logic       i_carrier_detect_flag,
    input  wire logic       i_data_set_ready_flag,
    input  wire logic       i_clear_to_send_flag,
    input  wire logic       i_call_progress_low_flag,
    input  wire logic       i_call_progress_high_flag,
    input  wire logic       i_low_exceeds_high_flag,
    input  wire logic       i_fast_carrier_flag,
    input  wire logic       i_tx_sync_flag,
    input  wire logic       i_handshake_timeout_flag,
    input  wire logic       i_tone_discrimination_flag,
    input  wire logic       i_answer_tone_flag,
    input  wire logic       i_remote_retrain_flag,
    input  wire logic       i_rx_sync_flag,
    input  wire logic       i_rate_negotiation_flag,
    input  wire logic       i_cleardown_flag,
    input  wire logic       i_touch_tone_digit_flag,
    input  wire logic [7:0] i_touch_tone_value,
    input  wire logic [15:0] i_tone_detector_output,
    input  wire logic [6:0] i_line_quality,
    input  wire logic       i_fsk_mode,
    input  wire logic       i_rx_data,
    // ring pin, asynchronous
    input  wire logic       i_ring_pin,
    // shared ram read port
    input  wire logic       i_host_rd,
    input  wire logic [5:0] i_host_addr,
    // outputs
    output logic [7:0]      o_host_rd_data,
    output logic            o_status_change_irq,
    output logic            o_rx_data,
    output logic            o_quality_valid
);

    // ring timing in baud ticks; least period rounds up, longest rounds down
    localparam int RING_LOST_I = (`MSR_RING_LOST_MS * BAUD_HZ) / 1000;
    localparam int RING_MAX_I  = BAUD_HZ / `MSR_RING_MIN_HZ;
    localparam int RING_MIN_I  = (BAUD_HZ + `MSR_RING_MAX_HZ - 1) / `MSR_RING_MAX_HZ;
    localparam logic [7:0] RING_LOST_TICKS = 8'(RING_LOST_I);
    localparam logic [7:0] RING_MAX_TICKS  = 8'(RING_MAX_I);
    localparam logic [7:0] RING_MIN_TICKS  = 8'(RING_MIN_I);

    // counters are 8 bits and the ring period byte too
    if (RING_MAX_I > 254 || RING_LOST_I < 1 || RING_MIN_I < 1) begin : g_bad_rate
        $error("BAUD_HZ gives ring counts the 8-bit counters cannot hold");
    end

    msr_state_t q;
    msr_state_t d;

    logic       ring_fall;
    logic       ring_edge;
    logic       ring_in_range;
    logic       tone_modes;
    logic       modem_mode;
    logic       digit_rise;
    logic [7:0] stat0_n;
    logic [7:0] stat1_n;
    logic [7:0] digit_n;
    logic [7:0] def0;
    logic [7:0] def1;
    logic [7:0] def2;
    logic       irq_n;

    // mode groups and ring edges seen after the synchroniser
    assign tone_modes    = (q.mode == MODE_TONE) || (q.mode == MODE_DTMF);
    assign modem_mode    = (q.mode == MODE_DATA) || (q.mode == MODE_FAX);
    assign ring_fall     = q.ring_prev && !q.ring_s2;
    assign ring_edge     = q.ring_prev != q.ring_s2;
    assign ring_in_range = (q.ring_cnt >= RING_MIN_TICKS) && (q.ring_cnt <= RING_MAX_TICKS);
    assign digit_rise    = (q.mode == MODE_DTMF) && i_touch_tone_digit_flag && !q.dtmf_prev;

    // new general status bytes, gated by the modes in which each bit means something
    always_comb begin
        stat0_n = 8'h00;
        stat1_n = 8'h00;
        stat0_n[`MSR_G0_CARRIER]      = modem_mode && i_carrier_detect_flag;
        stat0_n[`MSR_G0_DSR]          = modem_mode && i_data_set_ready_flag;
        stat0_n[`MSR_G0_CTS]          = modem_mode && i_clear_to_send_flag;
        stat0_n[`MSR_G0_BELL]         = tone_modes && (q.ring_st == RING_ON);
        stat0_n[`MSR_G0_CPT_LOW]      = tone_modes && i_call_progress_low_flag;
        stat0_n[`MSR_G0_CPT_HIGH]     = tone_modes && i_call_progress_high_flag;
        stat0_n[`MSR_G0_LOW_GT_HIGH]  = tone_modes && i_low_exceeds_high_flag;
        stat0_n[`MSR_G0_FAST_CARRIER] = (q.mode == MODE_FAX) && i_fast_carrier_flag;
        stat1_n[`MSR_G1_TX_SYNC]      = modem_mode && i_tx_sync_flag;
        stat1_n[`MSR_G1_TIMEOUT]      = (q.mode == MODE_DATA) && i_handshake_timeout_flag;
        stat1_n[`MSR_G1_TONE_DISC]    = i_tone_discrimination_flag;
        stat1_n[`MSR_G1_ANSWER_TONE]  = i_answer_tone_flag;
        // one bit, two meanings, picked by mode
        stat1_n[`MSR_G1_RETRAIN]      = (q.mode == MODE_FAX) ? i_rx_sync_flag
                                      : (q.mode == MODE_DATA) && i_remote_retrain_flag;
        stat1_n[`MSR_G1_RATE_NEG]     = (q.mode == MODE_DATA) && i_rate_negotiation_flag;
        stat1_n[`MSR_G1_CLEARDOWN]    = (q.mode == MODE_DATA) && i_cleardown_flag;
        stat1_n[`MSR_G1_DIGIT]        = (q.mode == MODE_DTMF) && i_touch_tone_digit_flag;
    end

    // masked compare against last baud's bytes
    assign irq_n = |(((stat0_n ^ q.stat0) & q.mask0) | ((stat1_n ^ q.stat1) & q.mask1));

    // digit captured at the flag's rise so the byte is valid with it
    assign digit_n = digit_rise ? i_touch_tone_value : q.digit;

    // mode defaults of the optional bytes; data, fax and voice layouts not carried
    always_comb begin
        def0 = 8'h00;
        def1 = 8'h00;
        def2 = 8'h00;
        if (tone_modes) begin
            def0 = i_tone_detector_output[7:0];
            def1 = i_tone_detector_output[15:8];
        end
        if (q.mode == MODE_TONE) begin
            def2 = q.ring_period;
        end else if (q.mode == MODE_DTMF) begin
            def2 = digit_n;
        end
    end

    // next state
    always_comb begin
        d = q;
        d.irq = 1'b0;

        // two-stage synchroniser for the ring pin
        d.ring_s1   = i_ring_pin;
        d.ring_s2   = q.ring_s1;
        d.ring_prev = q.ring_s2;

        // counters advance on baud ticks; any edge restarts the idle count, a fall restarts the period count
        if (i_baud_tick && q.ring_cnt != 8'hff) begin
            d.ring_cnt = q.ring_cnt + 8'h01;
        end
        if (i_baud_tick && q.ring_idle != 8'hff) begin
            d.ring_idle = q.ring_idle + 8'h01;
        end
        if (ring_edge) begin
            d.ring_idle = 8'h00;
        end
        // a tick in the cycle of the fall already belongs to the new period
        if (ring_fall) begin
            d.ring_cnt = i_baud_tick ? 8'h01 : 8'h00;
        end

        // ring detector: one in-range period to set, silence to clear
        unique case (q.ring_st)
            RING_IDLE: begin
                if (ring_fall) begin
                    d.ring_st = RING_ARMED;
                end
            end
            RING_ARMED: begin
                if (ring_fall && ring_in_range) begin
                    d.ring_st     = RING_ON;
                    d.ring_period = q.ring_cnt;
                end else if (!ring_edge && q.ring_idle >= RING_LOST_TICKS) begin
                    d.ring_st = RING_IDLE;
                end
            end
            RING_ON: begin
                if (ring_fall) begin
                    d.ring_period = q.ring_cnt;
                end else if (!ring_edge && q.ring_idle >= RING_LOST_TICKS) begin
                    d.ring_st = RING_IDLE;
                end
            end
            default: begin
                d.ring_st = RING_IDLE;
            end
        endcase

        // per-baud refresh of every status byte
        if (i_baud_tick) begin
            d.stat0      = stat0_n;
            d.stat1      = stat1_n;
            d.irq        = irq_n;
            d.quality    = {1'b0, i_line_quality};
            d.quality_ok = !i_fsk_mode;
            d.dtmf_prev  = i_touch_tone_digit_flag;
            d.digit      = digit_n;
            d.opt0       = q.src_sel[0] ? i_monitor_low  : def0;
            d.opt1       = q.src_sel[1] ? i_monitor_mid  : def1;
            d.opt2       = q.src_sel[2] ? i_monitor_high : def2;
        end

        // configure reloads the defaults; a same-cycle source select still wins
        if (i_configure_cmd) begin
            d.mode    = op_mode_t'(i_operating_mode_field);
            d.src_sel = 3'h0;
        end
        if (i_optional_source_select_cmd) begin
            d.src_sel = i_optional_source_sel;
        end
        if (i_select_status_irq_cmd) begin
            d.mask0 = i_irq_select0;
            d.mask1 = i_irq_select1;
        end

        // received data held at mark without carrier
        d.rxd = q.stat0[`MSR_G0_CARRIER] ? i_rx_data : 1'b1;

        // shared ram read port of the status area
        if (i_host_rd) begin
            unique case (i_host_addr)
                `MSR_ADDR_GENERAL0: d.rd_data = q.stat0;
                `MSR_ADDR_GENERAL1: d.rd_data = q.stat1;
                `MSR_ADDR_QUALITY:  d.rd_data = q.quality;
                `MSR_ADDR_OPT_LOW:  d.rd_data = q.opt0;
                `MSR_ADDR_OPT_MID:  d.rd_data = q.opt1;
                `MSR_ADDR_OPT_HIGH: d.rd_data = q.opt2;
                default:            d.rd_data = 8'h00;        // error byte kept elsewhere
            endcase
        end
    end

    // single register of all state
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            q             <= '0;
            q.ring_s1     <= 1'b0;
            q.ring_st     <= RING_IDLE;
            q.mode        <= MODE_TONE;
            q.mask0       <= `MSR_MASK0_RST;
            q.mask1       <= `MSR_MASK1_RST;
            q.ring_idle   <= 8'hff;
            q.rxd         <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign o_host_rd_data      = q.rd_data;
    assign o_status_change_irq = q.irq;
    assign o_rx_data           = q.rxd;
    assign o_quality_valid     = q.quality_ok;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    sequence s_ring_set;
        (q.ring_st == RING_ARMED) ##1 (q.ring_st == RING_ON);
    endsequence

    sequence s_digit_seen;
        i_baud_tick && digit_rise;
    endsequence

    a_irq_on_change: assert property (i_baud_tick && irq_n |=> o_status_change_irq)
        else $error("selected status change did not raise the interrupt");
    a_irq_only_tick: assert property (!i_baud_tick |=> !o_status_change_irq)
        else $error("interrupt raised outside a baud refresh");
    a_mask_reset: assert property ($past(i_sys_rst) |-> q.mask0 == 8'h3f && q.mask1 == 8'hff)
        else $error("interrupt selection not at default after reset");
    a_rx_mark: assert property (!q.stat0[0] |=> o_rx_data)
        else $error("received data not at mark without carrier");
    a_ring_period: assert property (s_ring_set |-> q.ring_period >= RING_MIN_TICKS && q.ring_period <= RING_MAX_TICKS)
        else $error("ring set with a period out of range");
    a_ring_lost: assert property (q.ring_st == RING_ON && q.ring_idle >= RING_LOST_TICKS && !ring_edge |=> q.ring_st == RING_IDLE)
        else $error("ring not cleared after silence");
    a_quality_max: assert property (q.quality <= `MSR_QUALITY_MAX)
        else $error("quality byte above its ceiling");
    a_digit_hold: assert property (!(i_baud_tick && digit_rise) |=> $stable(q.digit))
        else $error("touch-tone digit changed without a new digit");
    a_digit_load: assert property (s_digit_seen |=> q.digit == $past(i_touch_tone_value) && q.stat1[7])
        else $error("digit and flag not loaded together");
    a_configure_cmd_default: assert property (i_configure_cmd && !i_optional_source_select_cmd |=> q.src_sel == 3'h0)
        else $error("configure did not restore optional defaults");
    a_read_quality: assert property (i_host_rd && i_host_addr == 6'h0b |=> o_host_rd_data == $past(q.quality))
        else $error("quality location read wrong value");

endmodule

// *** host_reader_model.sv ***
// host controller model that reads the shared status ram of the block
`timescale 1ns/1ps
`include "modem_status_map.svh"

module host_reader_model (
    // clock
    input  wire logic       i_clk_sys,
    // shared ram read port
    output logic            o_host_rd,
    output logic [5:0]      o_host_addr,
    input  wire logic [7:0] i_host_rd_data
);
    // port idle until the first read
    initial begin
        o_host_rd   = 1'b0;
        o_host_addr = 6'h00;
    end

    // one byte: request held over the taking edge, data taken one cycle later
    task automatic read_byte(input logic [5:0] addr, output logic [7:0] data);
        @(negedge i_clk_sys);
        o_host_rd   = 1'b1;
        o_host_addr = addr;
        @(negedge i_clk_sys);
        data        = i_host_rd_data;
        o_host_rd   = 1'b0;
        o_host_addr = ~addr; // released address must not keep the old value
    endtask

    // tone discrimination only means something while the answer tone flag is up
    task automatic read_tone(output logic seen, output logic disc);
        logic [7:0] b;
        read_byte(`MSR_ADDR_GENERAL1, b);
        seen = b[`MSR_G1_ANSWER_TONE];
        disc = seen ? b[`MSR_G1_TONE_DISC] : 1'b0;
    endtask
endmodule

// *** tb.sv ***
// self-checking bench of the modem status reporting block
`timescale 1ns/1ps
`include "modem_status_map.svh"

module tb;
    import modem_status_pkg::*;

    // design pins
    logic        i_clk_sys, i_sys_rst, i_baud_tick, i_configure_cmd;
    logic        i_select_status_irq_cmd, i_optional_source_select_cmd;
    logic [2:0]  i_operating_mode_field, i_optional_source_sel;
    logic [7:0]  i_irq_select0, i_irq_select1, i_touch_tone_value;
    logic [7:0]  i_monitor_low, i_monitor_mid, i_monitor_high;
    logic [15:0] flags, i_tone_detector_output;
    logic [6:0]  i_line_quality;
    logic        rx_sync, i_fsk_mode, i_rx_data, i_ring_pin, i_host_rd;
    logic [5:0]  i_host_addr;
    logic [7:0]  o_host_rd_data;
    logic        o_status_change_irq, o_rx_data, o_quality_valid;
    // expectation model
    int          bad_count, samples_checked;
    logic [31:0] rng;
    op_mode_t    mode_m;
    logic [7:0]  m0, m1, g0_m, g1_m, digit_m;
    logic [2:0]  src_m;
    logic        prev_dig, dig_new;

    modem_status_reporting modem_status_reporting_i (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_baud_tick(i_baud_tick),
        .i_configure_cmd(i_configure_cmd), .i_operating_mode_field(i_operating_mode_field),
        .i_select_status_irq_cmd(i_select_status_irq_cmd), .i_irq_select0(i_irq_select0),
        .i_irq_select1(i_irq_select1),
        .i_optional_source_select_cmd(i_optional_source_select_cmd),
        .i_optional_source_sel(i_optional_source_sel), .i_monitor_low(i_monitor_low),
        .i_monitor_mid(i_monitor_mid), .i_monitor_high(i_monitor_high),
        .i_carrier_detect_flag(flags[0]), .i_data_set_ready_flag(flags[1]),
        .i_clear_to_send_flag(flags[2]), .i_call_progress_low_flag(flags[4]),
        .i_call_progress_high_flag(flags[5]), .i_low_exceeds_high_flag(flags[6]),
        .i_fast_carrier_flag(flags[7]), .i_tx_sync_flag(flags[8]),
        .i_handshake_timeout_flag(flags[9]), .i_tone_discrimination_flag(flags[10]),
        .i_answer_tone_flag(flags[11]), .i_remote_retrain_flag(flags[12]),
        .i_rx_sync_flag(rx_sync), .i_rate_negotiation_flag(flags[13]),
        .i_cleardown_flag(flags[14]), .i_touch_tone_digit_flag(flags[15]),
        .i_touch_tone_value(i_touch_tone_value), .i_tone_detector_output(i_tone_detector_output),
        .i_line_quality(i_line_quality), .i_fsk_mode(i_fsk_mode), .i_rx_data(i_rx_data),
        .i_ring_pin(i_ring_pin), .i_host_rd(i_host_rd), .i_host_addr(i_host_addr),
        .o_host_rd_data(o_host_rd_data), .o_status_change_irq(o_status_change_irq),
        .o_rx_data(o_rx_data), .o_quality_valid(o_quality_valid)
    );

    host_reader_model host_reader_model_i (
        .i_clk_sys(i_clk_sys), .o_host_rd(i_host_rd), .o_host_addr(i_host_addr),
        .i_host_rd_data(o_host_rd_data)
    );

    // 250 mhz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    // compare one observed value with its expectation
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // xorshift, repeatable from its fixed seed
    function automatic logic [31:0] next_rand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // first general byte; the ring bit is left to its own test
    function automatic logic [7:0] exp_g0(op_mode_t m, logic [15:0] f);
        logic modem, tones;
        modem = (m == MODE_DATA) || (m == MODE_FAX);
        tones = (m == MODE_TONE) || (m == MODE_DTMF);
        return {f[7] & (m == MODE_FAX), f[6:4] & {3{tones}}, 1'b0, f[2:0] & {3{modem}}};
    endfunction

    // second general byte; retrain in data mode, receiver sync in fax mode
    function automatic logic [7:0] exp_g1(op_mode_t m, logic [15:0] f, logic rs);
        logic d;
        d = (m == MODE_DATA);
        return {f[15] & (m == MODE_DTMF), f[14:13] & {2{d}}, d ? f[12] : (m == MODE_FAX) & rs,
                f[11:10], f[9] & d, f[8] & (d || (m == MODE_FAX))};
    endfunction

    // k: 0 configure, 1 interrupt select, 2 optional source select
    task automatic cmd(input int k, input logic [7:0] a, input logic [7:0] b);
        @(negedge i_clk_sys);
        {i_operating_mode_field, i_optional_source_sel} = {a[2:0], a[2:0]};
        {i_irq_select0, i_irq_select1} = {a, b};
        i_configure_cmd = (k == 0);
        i_select_status_irq_cmd = (k == 1);
        i_optional_source_select_cmd = (k == 2);
        @(negedge i_clk_sys);
        {i_configure_cmd, i_select_status_irq_cmd, i_optional_source_select_cmd} = 3'h0;
        if (k == 0) begin
            mode_m = op_mode_t'(a[2:0]);
            src_m = 3'h0;
        end
        if (k == 1) {m0, m1} = {a, b};
        if (k == 2) src_m = a[2:0];
    endtask

    // one baud with fresh pump levels; the interrupt pulse is looked at in its only cycle
    task automatic do_tick(input logic dig, input logic ring);
        logic [7:0] n0, n1;
        @(negedge i_clk_sys);
        {flags, i_tone_detector_output} = next_rand();
        flags[15] = dig;
        {i_monitor_low, i_monitor_mid, i_monitor_high, i_touch_tone_value} = next_rand();
        {rx_sync, i_fsk_mode, i_rx_data, i_line_quality} = 10'(next_rand());
        i_ring_pin = ring;
        i_baud_tick = 1'b1;
        n0 = exp_g0(mode_m, flags);
        n1 = exp_g1(mode_m, flags, rx_sync);
        @(negedge i_clk_sys);
        i_baud_tick = 1'b0;
        check(o_status_change_irq, |(((n0 ^ g0_m) & m0) | ((n1 ^ g1_m) & m1)));
        check(o_quality_valid, !i_fsk_mode);
        if (mode_m == MODE_DTMF && dig && !prev_dig) begin
            digit_m = i_touch_tone_value;
            dig_new = 1'b1;
        end
        {prev_dig, g0_m, g1_m} = {dig, n0, n1};
    endtask

    // read back the status area; digit byte only judged right after a new digit
    task automatic check_bytes();
        logic [7:0] b, e0, e1, e2;
        logic       tones, seen, disc;
        tones = (mode_m == MODE_TONE) || (mode_m == MODE_DTMF);
        e0 = src_m[0] ? i_monitor_low : (tones ? i_tone_detector_output[7:0] : 8'h00);
        e1 = src_m[1] ? i_monitor_mid : (tones ? i_tone_detector_output[15:8] : 8'h00);
        e2 = src_m[2] ? i_monitor_high : (tones ? digit_m : 8'h00);
        host_reader_model_i.read_byte(`MSR_ADDR_GENERAL0, b);
        check(b, g0_m);
        host_reader_model_i.read_byte(`MSR_ADDR_GENERAL1, b);
        check(b, g1_m);
        host_reader_model_i.read_byte(`MSR_ADDR_QUALITY, b);
        check(b, {1'b0, i_line_quality});
        host_reader_model_i.read_byte(`MSR_ADDR_OPT_LOW, b);
        check(b, e0);
        host_reader_model_i.read_byte(`MSR_ADDR_OPT_MID, b);
        check(b, e1);
        host_reader_model_i.read_byte(`MSR_ADDR_OPT_HIGH, b);
        if (src_m[2] || !tones || (mode_m == MODE_DTMF && dig_new)) check(b, e2);
        host_reader_model_i.read_byte(6'h0f + 6'(next_rand() % 49), b);
        check(b, 8'h00);
        host_reader_model_i.read_tone(seen, disc);
        check({seen, disc}, {g1_m[3], g1_m[3] & g1_m[2]});
        check(o_rx_data, g0_m[0] ? i_rx_data : 1'b1);
    endtask

    // reset for three cycles, then the whole area must read zero
    task automatic do_reset();
        logic [7:0] b;
        @(negedge i_clk_sys);
        i_sys_rst = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        {m0, m1, src_m} = {`MSR_MASK0_RST, `MSR_MASK1_RST, 3'h0};
        mode_m = MODE_TONE;
        {g0_m, g1_m, digit_m, prev_dig} = '0;
        check(o_status_change_irq, 1'b0);
        check(o_rx_data, 1'b1);
        check(o_quality_valid, 1'b0);
        for (int a = 8; a < 15; a++) begin
            host_reader_model_i.read_byte(a[5:0], b);
            check(b, 8'h00);
        end
        $display("reset test done");
    endtask

    // random bauds over every mode; masks stay at reset values for ten rounds
    task automatic rand_loop(input int n);
        for (int it = 0; it < n; it++) begin
            cmd(0, 8'(it % 5), 8'h00);
            if (it >= 10 && next_rand() % 2) cmd(2, 8'(next_rand()), 8'h00);
            if (it >= 10 && next_rand() % 3 == 0) cmd(1, 8'(next_rand()), 8'(next_rand()));
            dig_new = 1'b0;
            do_tick(1'b0, 1'b0);
            do_tick(1'(next_rand()), 1'b0);
            check_bytes();
        end
        $display("random test done, %0d rounds", n);
    endtask

    // end of run: counts, then verdict
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard: a run that outlives its budget counts as failed
    initial begin
        repeat (100000) @(posedge i_clk_sys);
        bad_count++;
        $display("[FAIL] t=%0t run budget used up", $time);
        give_verdict();
    end

    // main sequence; seed 69475
    initial begin
        logic [7:0] b;
        {rng, bad_count, samples_checked, dig_new} = {32'h00010f63, 32'h0, 32'h0, 1'b0};
        i_sys_rst = 1'b1;
        {i_baud_tick, i_configure_cmd, i_select_status_irq_cmd} = 3'h0;
        {i_optional_source_select_cmd, i_operating_mode_field, i_optional_source_sel} = '0;
        {i_irq_select0, i_irq_select1, i_monitor_low, i_monitor_mid, i_monitor_high} = '0;
        {i_touch_tone_value, flags, i_tone_detector_output, i_line_quality} = '0;
        {rx_sync, i_fsk_mode, i_rx_data, i_ring_pin} = 4'h0;
        do_reset();
        rand_loop(40);
        // ring of 40 bauds a period, three falls, then silence; interrupts masked off
        cmd(0, 8'(MODE_TONE), 8'h00);
        cmd(1, 8'h00, 8'h00);
        for (int k = 0; k < 180; k++) begin
            do_tick(1'b0, (k % 40) < 20 && k < 120);
            if (k == 59 || k == 119 || k == 179) begin
                host_reader_model_i.read_byte(`MSR_ADDR_GENERAL0, b);
                check(b[`MSR_G0_BELL], k == 119);
            end
            if (k == 119) begin
                host_reader_model_i.read_byte(`MSR_ADDR_OPT_HIGH, b);
                check(b, 8'h28);
            end
        end
        $display("ring test done");
        do_reset();
        rand_loop(12);
        give_verdict();
    end
endmodule
